// ===== src/ccr_pkg.sv
// Constants for the charger control register bank
package ccr_pkg;
    // Register offsets on the target register access port
    localparam logic [7:0] CCR_ADDR_INPUT_SOURCE   = 8'h00;
    localparam logic [7:0] CCR_ADDR_POWER_ON       = 8'h01;
    localparam logic [7:0] CCR_ADDR_CHARGE_CURRENT = 8'h02;
    localparam int         CCR_NUM_REGS            = 3;
    localparam logic [7:0] CCR_UNMAPPED_READ       = 8'hFF;

    // Values after power-on or register reset
    localparam logic [7:0] CCR_RESET_INPUT_SOURCE   = 8'h17;
    localparam logic [7:0] CCR_RESET_POWER_ON       = 8'h1A;
    localparam logic [7:0] CCR_RESET_CHARGE_CURRENT = 8'hA2;

    // Bits that also return to default on watchdog expiry
    localparam logic [7:0] CCR_WD_MASK_INPUT_SOURCE   = 8'h80;
    localparam logic [7:0] CCR_WD_MASK_POWER_ON       = 8'h70;
    localparam logic [7:0] CCR_WD_MASK_CHARGE_CURRENT = 8'hBF;

    // Field positions, input source control
    localparam int CCR_HIGHZ_BIT   = 7;
    localparam int CCR_IND_MSB     = 6;
    localparam int CCR_IND_LSB     = 5;
    localparam int CCR_ILIM_MSB    = 4;
    localparam int CCR_ILIM_LSB    = 0;
    // Field positions, power-on configuration
    localparam int CCR_PULSE_SKIP_DISABLE_BIT = 7;
    localparam int CCR_KICK_BIT    = 6;
    localparam int CCR_BOOST_BIT   = 5;
    localparam int CCR_CHG_BIT     = 4;
    localparam int CCR_SYSMIN_MSB  = 3;
    localparam int CCR_SYSMIN_LSB  = 1;
    localparam int CCR_OTG_SEL_BIT = 0;
    // Field positions, charge current control
    localparam int CCR_BLIM_BIT    = 7;
    localparam int CCR_FULLON_BIT  = 6;
    localparam int CCR_FAST_CHARGE_CURRENT_MSB    = 5;
    localparam int CCR_FAST_CHARGE_CURRENT_LSB    = 0;

    // Field codes
    localparam logic [1:0] CCR_IND_ENABLE      = 2'h0;
    localparam logic [1:0] CCR_IND_DISABLE     = 2'h3;
    localparam logic [4:0] CCR_ILIM_SEL_HIGH   = 5'h04;
    localparam logic [4:0] CCR_ILIM_SEL_LOW    = 5'h17;
    localparam logic [4:0] CCR_ILIM_SWITCH_MAX = 5'h06;
    localparam logic [5:0] CCR_FAST_CHARGE_CURRENT_MAX        = 6'h32;

    // Scales of decoded fields, mA and mV
    localparam logic [11:0] CCR_ILIM_OFFSET_MA = 12'h064;
    localparam logic [11:0] CCR_ILIM_STEP_MA   = 12'h064;
    localparam logic [11:0] CCR_FAST_CHARGE_CURRENT_STEP_MA   = 12'h03C;
    localparam logic [11:0] CCR_BLIM_LOW_MA    = 12'h1F4;
    localparam logic [11:0] CCR_BLIM_HIGH_MA   = 12'h4B0;
    localparam logic [11:0] CCR_OTG_FALL_HI_MV = 12'hAF0;
    localparam logic [11:0] CCR_OTG_FALL_LO_MV = 12'h9C4;
    localparam logic [11:0] CCR_OTG_RISE_MV    = 12'hBB8;
endpackage

// ===== src/ccr_field_decode.sv
// Registered decode of register fields into analog setpoints
module ccr_field_decode (
    // Clock, reset, enable
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_clock_enable,
    // Register contents and synchronised pin
    input  wire logic [7:0]  i_input_source,
    input  wire logic [7:0]  i_power_on,
    input  wire logic [7:0]  i_charge_current,
    input  wire logic        i_charge_pin_low,
    // Decoded setpoints
    output logic [11:0] o_input_limit_ma,
    output logic [11:0] o_fast_charge_ma,
    output logic [5:0]  o_fast_charge_code,
    output logic [11:0] o_system_floor_mv,
    output logic [11:0] o_otg_falling_mv,
    output logic [11:0] o_otg_rising_mv,
    output logic [11:0] o_boost_limit_ma,
    output logic        o_high_res_switch,
    output logic        o_charge_active
);
    logic [11:0] ilim_next, fast_charge_current_next, sysmin_next, otg_next, blim_next;
    logic [5:0]  code_next;
    logic        hires_next, active_next;
    logic [4:0]  ilim_code;
    logic        boost;

    // Field arithmetic and selection
    always_comb begin
        ilim_code   = i_input_source[ccr_pkg::CCR_ILIM_MSB:ccr_pkg::CCR_ILIM_LSB];
        boost       = i_power_on[ccr_pkg::CCR_BOOST_BIT];
        ilim_next   = ccr_pkg::CCR_ILIM_OFFSET_MA + 12'(ilim_code) * ccr_pkg::CCR_ILIM_STEP_MA; // R1
        code_next   = i_charge_current[ccr_pkg::CCR_FAST_CHARGE_CURRENT_MSB:ccr_pkg::CCR_FAST_CHARGE_CURRENT_LSB];
        if (code_next > ccr_pkg::CCR_FAST_CHARGE_CURRENT_MAX) begin
            code_next = ccr_pkg::CCR_FAST_CHARGE_CURRENT_MAX; // R15
        end
        fast_charge_current_next   = 12'(code_next) * ccr_pkg::CCR_FAST_CHARGE_CURRENT_STEP_MA; // R14
        unique case (i_power_on[ccr_pkg::CCR_SYSMIN_MSB:ccr_pkg::CCR_SYSMIN_LSB]) // R10
            3'h0: sysmin_next = 12'hA28;
            3'h1: sysmin_next = 12'hAF0;
            3'h2: sysmin_next = 12'hBB8;
            3'h3: sysmin_next = 12'hC80;
            3'h4: sysmin_next = 12'hD48;
            3'h5: sysmin_next = 12'hDAC;
            3'h6: sysmin_next = 12'hE10;
            3'h7: sysmin_next = 12'hE74;
        endcase
        otg_next    = i_power_on[ccr_pkg::CCR_OTG_SEL_BIT] ? ccr_pkg::CCR_OTG_FALL_LO_MV
                                                           : ccr_pkg::CCR_OTG_FALL_HI_MV; // R11
        blim_next   = i_charge_current[ccr_pkg::CCR_BLIM_BIT] ? ccr_pkg::CCR_BLIM_HIGH_MA
                                                              : ccr_pkg::CCR_BLIM_LOW_MA; // R12
        // Boost always uses the full switch, the mode bit is ignored there
        hires_next  = !boost && !i_charge_current[ccr_pkg::CCR_FULLON_BIT]
                      && (ilim_code < ccr_pkg::CCR_ILIM_SWITCH_MAX); // R13
        // Pin low, bit set, no boost, nonzero current
        active_next = i_charge_pin_low && i_power_on[ccr_pkg::CCR_CHG_BIT] && !boost // R8 R9
                      && (code_next != 6'h00); // R15
    end

    // Setpoint registers
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_input_limit_ma   <= 12'h000;
            o_fast_charge_ma   <= 12'h000;
            o_fast_charge_code <= 6'h00;
            o_system_floor_mv  <= 12'h000;
            o_otg_falling_mv   <= 12'h000;
            o_otg_rising_mv    <= 12'h000;
            o_boost_limit_ma   <= 12'h000;
            o_high_res_switch  <= 1'b0;
            o_charge_active    <= 1'b0;
        end else if (i_clock_enable) begin
            o_input_limit_ma   <= ilim_next;
            o_fast_charge_ma   <= fast_charge_current_next;
            o_fast_charge_code <= code_next;
            o_system_floor_mv  <= sysmin_next;
            o_otg_falling_mv   <= otg_next;
            o_otg_rising_mv    <= ccr_pkg::CCR_OTG_RISE_MV;
            o_boost_limit_ma   <= blim_next;
            o_high_res_switch  <= hires_next;
            o_charge_active    <= active_next;
        end
    end
endmodule

// ===== src/ccr_registers.sv
// Charger control register bank, offsets 0x00 to 0x02
//
// Operation
// [R1] Input current limit code means 100 mA plus 100 mA per step.
// [R2] Reset loads input current limit code 10111, a 2400 mA maximum.
// [R3] Source detection done loads 500 mA if select pin high, 2.4 A if low.
// [R4] Host writes after detection replace the automatically loaded limit.
// [R5] Indicator control 00 enables the pin, 01 reserved, 11 floats it.
// [R6] Bit 7 of offset 0 selects high-impedance input; watchdog clears it.
// [R7] Writing one to watchdog kick restarts timer; bit self-clears after restart.
// [R8] Boost enable overrides charge enable; no charging while boost enabled.
// [R9] Charging needs charge pin low and charge enable bit set, default one.
// [R10] System floor codes select 2.6 to 3.7 V, default 101 for 3.5 V.
// [R11] OTG floor bit selects 2.8 V or 2.5 V falling, 3.0 V rising.
// [R12] Boost limit bit selects 0.5 A or 1.2 A, default 1.2 A.
// [R13] Mode bit zero uses high-resistance switch below 700 mA, not in boost.
// [R14] Fast charge bits weigh 60 mA upward, default code 100010, 2040 mA.
// [R15] Fast charge code zero disables charging; codes above 110010 clamp there.
// [R16] Watchdog restores flagged fields; register reset restores all fields.
// [R17] Target answers at seven-bit address 6BH in standard or fast mode.
// [R18] Reads beyond the last implemented register return 0xFF.
// [R19] PFM disable bit defaults zero and resets only by register reset.
module ccr_registers (
    // Clock, reset, enable
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_clock_enable,
    // Register access port from the serial target engine
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic [7:0]  o_reg_rdata,
    output logic        o_addr_valid,
    // Events from charger logic
    input  wire logic        i_register_reset,
    input  wire logic        i_watchdog_expired,
    input  wire logic        i_watchdog_restarted,
    input  wire logic        i_source_detect_done,
    // Asynchronous pins
    input  wire logic        i_source_select_pin,
    input  wire logic        i_charge_enable_pin_n,
    // Control outputs
    output logic        o_watchdog_kick,
    output logic        o_input_highz,
    output logic        o_indicator_enable,
    output logic        o_pfm_disable,
    output logic        o_boost_enable,
    output logic [11:0] o_input_limit_ma,
    output logic [11:0] o_fast_charge_ma,
    output logic [5:0]  o_fast_charge_code,
    output logic [11:0] o_system_floor_mv,
    output logic [11:0] o_otg_falling_mv,
    output logic [11:0] o_otg_rising_mv,
    output logic [11:0] o_boost_limit_ma,
    output logic        o_high_res_switch,
    output logic        o_charge_active
);
    localparam logic [7:0] RESET_VAL [ccr_pkg::CCR_NUM_REGS] = '{ccr_pkg::CCR_RESET_INPUT_SOURCE,
        ccr_pkg::CCR_RESET_POWER_ON, ccr_pkg::CCR_RESET_CHARGE_CURRENT};
    localparam logic [7:0] WD_MASK [ccr_pkg::CCR_NUM_REGS] = '{ccr_pkg::CCR_WD_MASK_INPUT_SOURCE,
        ccr_pkg::CCR_WD_MASK_POWER_ON, ccr_pkg::CCR_WD_MASK_CHARGE_CURRENT};

    logic [7:0] regs_reg  [ccr_pkg::CCR_NUM_REGS];
    logic [7:0] regs_next [ccr_pkg::CCR_NUM_REGS];
    logic [1:0] sel_sync_reg, sel_sync_next, ce_sync_reg, ce_sync_next;
    logic [7:0] rdata_next;
    logic       sel_high, charge_pin_low;

    // Pin synchronisers; only the second stage is read
    always_comb begin
        sel_sync_next  = {sel_sync_reg[0], i_source_select_pin};
        ce_sync_next   = {ce_sync_reg[0], i_charge_enable_pin_n};
        sel_high       = sel_sync_reg[1];
        charge_pin_low = !ce_sync_reg[1];
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sel_sync_reg <= 2'h0;
            ce_sync_reg  <= 2'h3;
        end else if (i_clock_enable) begin
            sel_sync_reg <= sel_sync_next;
            ce_sync_reg  <= ce_sync_next;
        end
    end

    // Per-register next state: register reset, watchdog, host write, hardware
    // updates; the host write wins over detection so a late write sticks
    for (genvar g = 0; g < ccr_pkg::CCR_NUM_REGS; g++) begin : g_reg
        always_comb begin
            regs_next[g] = regs_reg[g];
            if (g == 0 && i_source_detect_done) begin
                regs_next[g][ccr_pkg::CCR_ILIM_MSB:ccr_pkg::CCR_ILIM_LSB] =
                    sel_high ? ccr_pkg::CCR_ILIM_SEL_HIGH : ccr_pkg::CCR_ILIM_SEL_LOW; // R3
            end
            if (g == 1 && i_watchdog_restarted) begin
                regs_next[g][ccr_pkg::CCR_KICK_BIT] = 1'b0; // R7
            end
            if (i_reg_write && i_reg_addr == 8'(g)) begin
                regs_next[g] = i_reg_wdata; // R4
            end
            if (i_watchdog_expired) begin
                regs_next[g] = (regs_next[g] & ~WD_MASK[g]) | (RESET_VAL[g] & WD_MASK[g]); // R6 R16
            end
            if (i_register_reset) begin
                regs_next[g] = RESET_VAL[g]; // R16 R19
            end
        end

        always_ff @(posedge i_clock) begin
            if (i_reset) begin
                regs_reg[g] <= RESET_VAL[g]; // R2
            end else if (i_clock_enable) begin
                regs_reg[g] <= regs_next[g];
            end
        end
    end

    // Address check and read data; unmapped reads give all ones
    always_comb begin
        o_addr_valid = i_reg_addr < 8'(ccr_pkg::CCR_NUM_REGS);
        rdata_next   = o_reg_rdata;
        if (i_reg_read) begin
            rdata_next = o_addr_valid ? regs_reg[i_reg_addr[1:0]] : ccr_pkg::CCR_UNMAPPED_READ; // R18
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
        end else if (i_clock_enable) begin
            o_reg_rdata <= rdata_next;
        end
    end

    // Control bits straight from the register flops
    assign o_input_highz      = regs_reg[0][ccr_pkg::CCR_HIGHZ_BIT]; // R6
    // Reserved codes leave the pin enabled; only 11 floats it
    assign o_indicator_enable = regs_reg[0][ccr_pkg::CCR_IND_MSB:ccr_pkg::CCR_IND_LSB]
                                != ccr_pkg::CCR_IND_DISABLE; // R5
    assign o_pfm_disable      = regs_reg[1][ccr_pkg::CCR_PULSE_SKIP_DISABLE_BIT]; // R19
    assign o_watchdog_kick    = regs_reg[1][ccr_pkg::CCR_KICK_BIT]; // R7
    assign o_boost_enable     = regs_reg[1][ccr_pkg::CCR_BOOST_BIT];

    // Setpoint decode, one cycle behind the registers
    ccr_field_decode u_decode (
        .i_clock            (i_clock),
        .i_reset            (i_reset),
        .i_clock_enable     (i_clock_enable),
        .i_input_source     (regs_reg[0]),
        .i_power_on         (regs_reg[1]),
        .i_charge_current   (regs_reg[2]),
        .i_charge_pin_low   (charge_pin_low),
        .o_input_limit_ma   (o_input_limit_ma),
        .o_fast_charge_ma   (o_fast_charge_ma),
        .o_fast_charge_code (o_fast_charge_code),
        .o_system_floor_mv  (o_system_floor_mv),
        .o_otg_falling_mv   (o_otg_falling_mv),
        .o_otg_rising_mv    (o_otg_rising_mv),
        .o_boost_limit_ma   (o_boost_limit_ma),
        .o_high_res_switch  (o_high_res_switch),
        .o_charge_active    (o_charge_active)
    );

    // Checks; all but reset_defaults_a, freeze_a and charge_clamp_a are gated by the enable, as a frozen cycle moves nothing
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    // Cycles in which only host writes and hardware updates move the registers
    logic quiet;
    assign quiet = i_clock_enable && !i_register_reset && !i_watchdog_expired;

    // Register contents
    reset_defaults_a: assert property ($past(i_reset) |-> regs_reg[0] == 8'h17 // R2
        && regs_reg[1] == 8'h1A && regs_reg[2] == 8'hA2) else $error("reset defaults wrong");
    reg_reset_a: assert property (i_clock_enable && i_register_reset |=> regs_reg[0] == 8'h17 // R16
        && regs_reg[1] == 8'h1A && regs_reg[2] == 8'hA2) else $error("register reset incomplete");
    detect_load_a: assert property (quiet && i_source_detect_done // R3
        && !(i_reg_write && i_reg_addr == 8'h00) |=> regs_reg[0][4:0] == ($past(sel_high) ? 5'h04 : 5'h17))
        else $error("detection load wrong");
    host_override_a: assert property (quiet && i_reg_write && i_reg_addr == 8'h00 // R4
        |=> regs_reg[0] == $past(i_reg_wdata)) else $error("host write lost");
    unmapped_read_a: assert property (i_clock_enable && i_reg_read && i_reg_addr > 8'h02 // R18
        |=> o_reg_rdata == 8'hFF) else $error("unmapped read not all ones");
    watchdog_restore_a: assert property (i_clock_enable && i_watchdog_expired && !i_register_reset // R16
        |=> !o_input_highz && !o_watchdog_kick && !o_boost_enable && regs_reg[1][4]
        && regs_reg[2][7] && regs_reg[2][5:0] == 6'h22) else $error("watchdog restore wrong");
    kick_clear_a: assert property (quiet && o_watchdog_kick && i_watchdog_restarted // R7
        && !(i_reg_write && i_reg_addr == 8'h01) |=> !o_watchdog_kick) else $error("kick not cleared");
    kick_hold_a: assert property (quiet && o_watchdog_kick && !i_watchdog_restarted // R7
        && !(i_reg_write && i_reg_addr == 8'h01) |=> o_watchdog_kick) else $error("kick dropped early");
    pfm_sticky_a: assert property (quiet && !(i_reg_write && i_reg_addr == 8'h01) // R19
        |=> o_pfm_disable == $past(o_pfm_disable)) else $error("pfm bit changed");
    kick_write_wins_a: assert property (quiet && i_reg_write && i_reg_addr == 8'h01 && i_reg_wdata[6] // R7
        |=> o_watchdog_kick) else $error("kick write lost");
    freeze_a: assert property (!i_clock_enable |=> $stable(regs_reg[0]) && $stable(regs_reg[1])
        && $stable(regs_reg[2]) && $stable(o_reg_rdata)) else $error("state moved while frozen");
    unmapped_write_a: assert property (quiet && i_reg_write && i_reg_addr > 8'h02 && !i_source_detect_done
        && !i_watchdog_restarted |=> $stable(regs_reg[0]) && $stable(regs_reg[1]) && $stable(regs_reg[2]))
        else $error("unmapped write landed");

    // Decoded setpoints, one enabled cycle behind the registers
    boost_priority_a: assert property (i_clock_enable && o_boost_enable |=> !o_charge_active) // R8
        else $error("charging during boost");
    boost_switch_a: assert property (i_clock_enable && o_boost_enable |=> !o_high_res_switch) // R13
        else $error("reduced switch in boost");
    pin_block_a: assert property (i_clock_enable && !charge_pin_low |=> !o_charge_active) // R9
        else $error("charging with pin high");
    zero_current_a: assert property (i_clock_enable && regs_reg[2][5:0] == 6'h00 |=> !o_charge_active) // R15
        else $error("charging at zero current");
    charge_clamp_a: assert property (o_fast_charge_code <= 6'h32 // R15
        && o_fast_charge_ma <= 12'hBB8) else $error("fast charge not clamped");

    // Main scenarios reached
    detect_c:   cover property (i_clock_enable && i_source_detect_done);
    wd_c:       cover property (i_clock_enable && i_watchdog_expired);
    unmapped_c: cover property (i_clock_enable && i_reg_read && !o_addr_valid);
    boost_c:    cover property (o_boost_enable && charge_pin_low);
    kick_c:     cover property (o_watchdog_kick && i_watchdog_restarted);
endmodule

// ===== tb/ccr_host_model.sv
// Host-side model that drives the register access port one byte at a time
module ccr_host_model (
    // Clock
    input  wire logic       i_clock,
    // Register access port
    output logic            o_reg_write,
    output logic            o_reg_read,
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata,
    input  wire logic [7:0] i_reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Seven-bit target address that the serial engine answers to
    localparam logic [6:0] TARGET_ADDR = 7'h6B;
    // Idle strobes at time zero
    initial begin
        o_reg_write = 1'b0;
        o_reg_read = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // Released lines show the inverse, so a stale address never passes as held
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd);
        @(posedge i_clock);
        o_reg_write <= wr;
        o_reg_read <= !wr;
        o_reg_addr <= addr;
        o_reg_wdata <= data;
        @(posedge i_clock);
        o_reg_write <= 1'b0;
        o_reg_read <= 1'b0;
        o_reg_addr <= ~addr;
        o_reg_wdata <= ~data;
        #1;
        rd = i_reg_rdata;
    endtask
endmodule

// ===== tb/test_charger_control_registers.sv
// Self-checking bench for the charger control register bank
module test_charger_control_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, ce, wr, rd, sel, pin_n, kick, highz, ind, boost, hres, chg, av, pfm;
    logic [3:0]  ev;
    logic [7:0]  addr, wdata, rdata, v;
    logic [11:0] ilim, fast_charge_current, sysmv, ofall, orise, blim;
    logic [5:0]  icode;
    int          err_total, cmp_count;
    int          ic[4] = '{0, 5, 6, 31};
    int          mv[8] = '{2600, 2800, 3000, 3200, 3400, 3500, 3600, 3700};
    int          fc[4] = '{0, 1, 50, 63};
    logic [7:0]  wv[3] = '{8'hEA, 8'hF0, 8'h45};
    logic [7:0]  wd[3] = '{8'h6A, 8'h90, 8'hE2};
    logic [7:0]  df[3] = '{8'h17, 8'h1A, 8'hA2};

    // Host side of the register port
    ccr_host_model host (.i_clock(clk), .o_reg_write(wr), .o_reg_read(rd), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .i_reg_rdata(rdata));
    // Device under test
    ccr_registers uut (.i_clock(clk), .i_reset(rst), .i_clock_enable(ce), .i_reg_write(wr),
        .i_reg_read(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_addr_valid(av),
        .i_register_reset(ev[0]), .i_watchdog_expired(ev[1]), .i_watchdog_restarted(ev[2]),
        .i_source_detect_done(ev[3]), .i_source_select_pin(sel), .i_charge_enable_pin_n(pin_n),
        .o_watchdog_kick(kick), .o_input_highz(highz), .o_indicator_enable(ind), .o_pfm_disable(pfm),
        .o_boost_enable(boost), .o_input_limit_ma(ilim), .o_fast_charge_ma(fast_charge_current), .o_fast_charge_code(icode),
        .o_system_floor_mv(sysmv), .o_otg_falling_mv(ofall), .o_otg_rising_mv(orise),
        .o_boost_limit_ma(blim), .o_high_res_switch(hres), .o_charge_active(chg));

    // Compare and count
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.access(1'b1, a, d, unused);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, v);
        chk({4'h0, v}, {4'h0, e});
    endtask
    // Decoded outputs trail the registers by one enabled cycle
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // One-cycle event pulse on line k
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev <= 4'h0;
        #1;
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    initial begin
        #200000;
        err_total++;
        end_sim;
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        sel = 1'b0;
        pin_n = 1'b0;
        ev = 4'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        settle;
        for (int a = 0; a < 3; a++) rchk(8'(a), df[a]);
        chk(ilim, 12'h960);
        chk(fast_charge_current, 12'h7F8);
        chk(sysmv, 12'hDAC);
        chk(ofall, 12'hAF0);
        chk(orise, 12'hBB8);
        chk(blim, 12'h4B0);
        chk({11'h000, chg}, 12'h001);
        // Limit codes at both ends and around the switch threshold
        foreach (ic[i]) begin
            wreg(8'h00, 8'(ic[i]));
            settle;
            chk(ilim, 12'(100 + 100 * ic[i]));
            chk({11'h000, hres}, {11'h000, ic[i] < 6});
        end
        // Every indicator code, high-impedance on the last
        for (int i = 0; i < 4; i++) begin
            wreg(8'h00, {i == 3, 2'(i), 5'h17});
            settle;
            chk({11'h000, ind}, {11'h000, i != 3});
            chk({11'h000, highz}, {11'h000, i == 3});
        end
        for (int i = 0; i < 8; i++) begin
            wreg(8'h01, {4'h1, 3'(i), i == 7});
            settle;
            chk(sysmv, 12'(mv[i]));
            chk(ofall, (i == 7) ? 12'h9C4 : 12'hAF0);
        end
        // Zero, smallest, largest and clamped charge codes
        foreach (fc[i]) begin
            wreg(8'h02, 8'(fc[i]));
            settle;
            chk({6'h00, icode}, 12'((fc[i] > 50) ? 50 : fc[i]));
            chk(fast_charge_current, 12'(60 * ((fc[i] > 50) ? 50 : fc[i])));
            chk({11'h000, chg}, {11'h000, fc[i] != 0});
            chk(blim, 12'h1F4);
        end
        wreg(8'h00, 8'h05);
        wreg(8'h02, 8'h62);
        settle;
        chk({11'h000, hres}, 12'h000);
        wreg(8'h02, 8'h22);
        wreg(8'h01, 8'h3A);
        settle;
        chk({10'h000, boost, chg}, 12'h002);
        chk({11'h000, hres}, 12'h000);
        wreg(8'h01, 8'h0A);
        settle;
        chk({11'h000, chg}, 12'h000);
        wreg(8'h01, 8'h1A);
        settle;
        chk({10'h000, chg, hres}, 12'h003);
        @(posedge clk);
        pin_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk({11'h000, chg}, 12'h000);
        pin_n <= 1'b0;
        // Kick sets, then clears itself once the timer has restarted
        wreg(8'h01, 8'h5A);
        chk({11'h000, kick}, 12'h001);
        pulse(2);
        chk({11'h000, kick}, 12'h000);
        rchk(8'h01, 8'h1A);
        // Watchdog expiry keeps unflagged bits, register reset restores all defaults
        for (int a = 0; a < 3; a++) wreg(8'(a), wv[a]);
        pulse(1);
        chk({11'h000, pfm}, 12'h001);
        for (int a = 0; a < 3; a++) rchk(8'(a), wd[a]);
        pulse(0);
        chk({11'h000, pfm}, 12'h000);
        for (int a = 0; a < 3; a++) rchk(8'(a), df[a]);
        // Source detection, then a host override
        sel <= 1'b1;
        repeat (3) @(posedge clk);
        pulse(3);
        rchk(8'h00, 8'h04);
        settle;
        chk(ilim, 12'h1F4);
        sel <= 1'b0;
        repeat (3) @(posedge clk);
        pulse(3);
        rchk(8'h00, 8'h17);
        wreg(8'h00, 8'h0A);
        rchk(8'h00, 8'h0A);
        // Unmapped write ignored, unmapped reads return all ones
        wreg(8'h03, 8'h00);
        rchk(8'h00, 8'h0A);
        rchk(8'h03, 8'hFF);
        // The host parks the inverse address: 0xFC after the first read, 0x00 after the second
        chk({11'h000, av}, 12'h000);
        rchk(8'hFF, 8'hFF);
        chk({11'h000, av}, 12'h001);
        // Nothing is taken while the enable is low
        @(posedge clk);
        ce <= 1'b0;
        wreg(8'h00, 8'h11);
        ce <= 1'b1;
        rchk(8'h00, 8'h0A);
        end_sim;
    end
endmodule
